// ---- logic/tsgm_pkg.sv ----
package tsgm_pkg;

   // Width of the mode field and its four codes.
   localparam int          MODE_W        = 2;
   localparam logic [1:0]  MODE_SINE     = 2'h0;
   localparam logic [1:0]  MODE_DC       = 2'h1;
   localparam logic [1:0]  MODE_DATA     = 2'h2;
   localparam logic [1:0]  MODE_PULSE    = 2'h3;

   // Field widths of the configuration word, the outputs and the sine path.
   localparam int          RANGE_W       = 3;
   localparam int          NUM_W         = 4;
   localparam int          DEN_W         = 8;
   localparam int          ATTEN_W       = 8;
   localparam int          LEVEL_W       = 24;
   localparam int          PCODE_W       = 5;
   localparam int          PLEVEL_W      = 16;
   localparam int          PHASE_W       = 10;
   localparam int          TABLE_W       = 16;
   localparam int          TOTAL_W       = 9;

   // Master clock rate at which the frequency relation is exact, and the sample divider.
   localparam int          REF_RATE_HZ   = 4096000;
   localparam int          SAMPLE_DIV    = 16;

   // Attenuation arithmetic: 0.5 dB steps, twelve steps to one 6 dB binary shift.
   localparam int          STEPS_PER_6DB = 12;
   localparam logic [3:0]  MUTE_NIBBLE   = 4'hf;
   localparam logic [TOTAL_W-1:0] TOTAL_MUTE = 9'h1ff;
   localparam logic [RANGE_W-1:0] RANGE_MAX  = 3'h6;

   // Pulse code layout: sign bit and four magnitude bits.
   localparam int          PCODE_SIGN    = 4;
   localparam logic [4:0]  PCODE_STEPS   = 5'h10;

   // Reset values of the output samples.
   localparam logic [LEVEL_W-1:0]  SAMPLE_RST = 24'h000000;
   localparam logic [PLEVEL_W-1:0] PLEVEL_RST = 16'h0000;

   // Active data path, one-hot.
   typedef enum logic [3:0] {
      TSGM_PATH_SINE  = 4'b0001,
      TSGM_PATH_DC    = 4'b0010,
      TSGM_PATH_DATA  = 4'b0100,
      TSGM_PATH_PULSE = 4'b1000
   } tsgm_path_t;

   // Configuration bits that software sets.
   typedef struct packed {
      logic [MODE_W-1:0]  mode;
      logic [RANGE_W-1:0] range_code;
      logic               rate_halving_bit;
      logic [NUM_W-1:0]   numerator;
      logic [DEN_W-1:0]   denominator;
      logic [ATTEN_W-1:0] sine_attenuation_code;
      logic [LEVEL_W-1:0] constant_level_word;
      logic [PCODE_W-1:0] first_pulse_level;
      logic [PCODE_W-1:0] second_pulse_level;
   } tsgm_cfg_t;

   // Whole register state of the generator.
   typedef struct packed {
      logic                       sync_s1;
      logic                       sync_s2;
      logic                       sw_s1;
      logic                       sw_s2;
      logic [7:0]                 div_cnt;
      logic                       tick;
      tsgm_path_t                 path;
      logic [PHASE_W-1:0]         phase;
      logic [DEN_W:0]             rem;
      logic                       half;
      logic signed [LEVEL_W-1:0]  sample;
      logic [PCODE_W-1:0]         pulse_code;
      logic signed [PLEVEL_W-1:0] pulse_level;
      logic                       bit_out;
      logic                       bit_valid;
      logic                       switch_en;
      logic [RANGE_W-1:0]         range_out;
      logic [TOTAL_W-1:0]         total_atten;
   } tsgm_state_t;

endpackage

// ---- logic/tsgm_sine_rom.sv ----
`timescale 1ns/1ps
// Full-wave sine from a 257-entry quarter table built at elaboration.
module tsgm_sine_rom
   import tsgm_pkg::*;
(
   input  wire logic [PHASE_W-1:0]        phase,
   output      logic signed [TABLE_W-1:0] value
);
   import tsgm_pkg::*;

   localparam int QPTS = 1 << (PHASE_W - 2);   // Points in one quarter wave.

   // Quarter-wave value at index i, scaled to the positive full scale.
   function automatic int quarter_val(int i);
      real x;
      x = $sin(3.14159265358979 * 0.5 * i / QPTS) * 32767.0;
      return $rtoi(x + 0.5);
   endfunction

   logic signed [TABLE_W-1:0] rom [QPTS+1];   // Quarter table including the peak.
   logic [PHASE_W-2:0]        idx;            // Index into the quarter table.

   // Fill the table with constants.
   for (genvar g = 0; g <= QPTS; g++) begin : g_rom
      assign rom[g] = TABLE_W'(quarter_val(g));
   end

   // Fold the phase into the first quadrant and restore the sign.
   always_comb begin
      if (phase[PHASE_W-2]) begin
         idx = (PHASE_W-1)'(QPTS) - (PHASE_W-1)'(phase[PHASE_W-3:0]);
      end else begin
         idx = (PHASE_W-1)'(phase[PHASE_W-3:0]);
      end
      // Second half of the cycle is the negative of the first.
      value = phase[PHASE_W-1] ? -rom[idx] : rom[idx];
   end

endmodule

// ---- logic/tsgm_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Two-bit mode picks sine, dc, data, pulse.
// - Sine rate 250/2^H times (num+1)/(den+1), for num up to den.
// - Sine rate scales with the master clock.
// - Writing numerator or denominator restarts at zero.
// - Sync high in sine mode zeroes phase.
// - Three-bit range code, 6 dB per step.
// - Digital attenuation 0.5 dB steps, 1111xxxx mutes.
// - Total attenuation is range plus digital.
// - Dc mode outputs the 24-bit level word.
// - Dc level word is two's complement.
// - Pulse levels ignore the analog range code.
// - Sync low picks first, high second level.
// - Pulse code decodes to log-spaced levels.
// - Data mode samples bitstream at clock/16.
// - Data output follows the bitstream ones-density.
module tsgm_top
   import tsgm_pkg::*;
#(
   parameter int DIV = SAMPLE_DIV   // Master clocks per modulator sample.
)(
   input  wire logic                       REF_CLK,
   input  wire logic                       RESETN,
   input  wire tsgm_pkg::tsgm_cfg_t        CFG,
   input  wire logic                       RATIO_WR,
   input  wire logic                       SYNC_IN,
   input  wire logic                       SWITCH_OR_BITSTREAM_INPUT,
   output      tsgm_pkg::tsgm_path_t       ACTIVE_PATH,
   output      logic                       SAMPLE_TICK,
   output      logic signed [23:0]         MOD_SAMPLE,
   output      logic                       DATA_BIT,
   output      logic                       DATA_BIT_VALID,
   output      logic                       SWITCH_ENABLE,
   output      logic [4:0]                 PULSE_CODE,
   output      logic signed [15:0]         PULSE_LEVEL,
   output      logic [2:0]                 RANGE_OUT,
   output      logic [8:0]                 TOTAL_ATTEN
);
   import tsgm_pkg::*;

   // The divider counter is eight bits wide and must give at least two clocks per sample.
   if (DIV < 2 || DIV > 256) begin : g_chk
      $error("DIV must lie between 2 and 256.");
   end

   localparam logic [7:0] DIV_LAST = 8'(DIV - 1);   // Last count of the sample divider.

   tsgm_state_t               s;         // Registered state.
   tsgm_state_t               n;         // Next state.
   logic signed [TABLE_W-1:0] sine_val;  // Raw sine at the present phase.

   // Decode the two-bit mode field into the one-hot data path.
   function automatic tsgm_path_t path_decode(logic [MODE_W-1:0] m);
      tsgm_path_t p;
      unique case (m)
         MODE_SINE:  p = TSGM_PATH_SINE;
         MODE_DC:    p = TSGM_PATH_DC;
         MODE_DATA:  p = TSGM_PATH_DATA;
         MODE_PULSE: p = TSGM_PATH_PULSE;
      endcase
      return p;
   endfunction

   // Gain of one 0.5 dB step within a 6 dB octave, unsigned with 16 fraction bits.
   function automatic logic [15:0] step_gain(logic [3:0] j);
      logic [15:0] g;
      unique case (j)
         4'h0:    g = 16'hffff;
         4'h1:    g = 16'hf1ad;
         4'h2:    g = 16'he428;
         4'h3:    g = 16'hd765;
         4'h4:    g = 16'hcb58;
         4'h5:    g = 16'hbff8;
         4'h6:    g = 16'hb53b;
         4'h7:    g = 16'hab18;
         4'h8:    g = 16'ha186;
         4'h9:    g = 16'h987c;
         4'ha:    g = 16'h8ff5;
         4'hb:    g = 16'h87e7;
         default: g = 16'h0000;
      endcase
      return g;
   endfunction

   // Apply the digital attenuation to a sine value and widen it to the sample width.
   function automatic logic signed [LEVEL_W-1:0] attenuate(logic signed [TABLE_W-1:0] v,
                                                           logic [ATTEN_W-1:0] code);
      logic [ATTEN_W-1:0]  shift;
      logic [3:0]          frac;
      logic signed [32:0]  prod;
      logic signed [23:0]  wide;
      shift = code / ATTEN_W'(STEPS_PER_6DB);
      frac  = 4'(code % ATTEN_W'(STEPS_PER_6DB));
      prod  = 33'(v) * $signed({1'b0, step_gain(frac)});
      wide  = prod[31:8];
      if (code[7:4] == MUTE_NIBBLE) begin
         wide = SAMPLE_RST;                 // Full mute.
      end else begin
         wide = wide >>> shift;             // Whole 6 dB octaves are binary shifts.
      end
      return wide;
   endfunction

   // Map a pulse code onto its approximately logarithmic level.
   function automatic logic signed [PLEVEL_W-1:0] pulse_decode(logic [PCODE_W-1:0] c);
      logic [3:0]          mag;
      logic [PLEVEL_W-1:0] lvl;
      // Negative codes count down from the full scale at 10001.
      mag = c[PCODE_SIGN] ? 4'(PCODE_STEPS - c) : c[3:0];
      unique case (mag)
         4'h0:    lvl = 16'h0000;
         4'h1:    lvl = 16'h0106;
         4'h2:    lvl = 16'h017c;
         4'h3:    lvl = 16'h01ff;
         4'h4:    lvl = 16'h02f8;
         4'h5:    lvl = 16'h03fe;
         4'h6:    lvl = 16'h05fe;
         4'h7:    lvl = 16'h07fd;
         4'h8:    lvl = 16'h0bfb;
         4'h9:    lvl = 16'h0ff9;
         4'ha:    lvl = 16'h1803;
         4'hb:    lvl = 16'h2000;
         4'hc:    lvl = 16'h3006;
         4'hd:    lvl = 16'h4000;
         4'he:    lvl = 16'h6041;
         default: lvl = 16'h7fff;
      endcase
      return c[PCODE_SIGN] ? -$signed(lvl) : $signed(lvl);
   endfunction

   // Sine table lookup at the present phase.
   tsgm_sine_rom u_rom (
      .phase (s.phase),
      .value (sine_val)
   );

   // Next-state logic for the whole generator.
   always_comb begin
      logic [DEN_W:0] sum;
      sum = '0;
      n   = s;

      // Pins from outside pass two flip-flops before use.
      n.sync_s1 = SYNC_IN;
      n.sync_s2 = s.sync_s1;
      n.sw_s1   = SWITCH_OR_BITSTREAM_INPUT;
      n.sw_s2   = s.sw_s1;

      // Sample divider: one tick every DIV master clocks, so all rates follow the clock.
      n.tick    = (s.div_cnt == DIV_LAST);
      n.div_cnt = (s.div_cnt == DIV_LAST) ? 8'h00 : s.div_cnt + 8'h01;

      // Operating path follows the mode field.
      n.path = path_decode(CFG.mode);

      // Phase accumulator: a remainder in units of 1/(den+1) advances by num+1 per tick.
      if (RATIO_WR) begin
         n.phase = '0;
         n.rem   = '0;
         n.half  = 1'b0;
      end else if (s.path == TSGM_PATH_SINE && s.sync_s2) begin
         n.phase = '0;
         n.rem   = '0;
         n.half  = 1'b0;
      end else if (s.tick && s.path == TSGM_PATH_SINE) begin
         sum = s.rem + (DEN_W+1)'(CFG.numerator) + (DEN_W+1)'(1);
         if (sum >= (DEN_W+1)'(CFG.denominator) + (DEN_W+1)'(1)) begin
            n.rem = sum - (DEN_W+1)'(CFG.denominator) - (DEN_W+1)'(1);
            // The halving bit lets only every second carry move the phase.
            if (CFG.rate_halving_bit && !s.half) begin
               n.half = 1'b1;
            end else begin
               n.half  = 1'b0;
               n.phase = s.phase + PHASE_W'(1);
            end
         end else begin
            n.rem = sum;
         end
      end

      // Modulator sample, refreshed once per tick.
      n.bit_valid = 1'b0;
      if (s.tick) begin
         unique case (s.path)
            TSGM_PATH_SINE: begin
               n.sample = attenuate(sine_val, CFG.sine_attenuation_code);
            end
            TSGM_PATH_DC: begin
               n.sample = $signed(CFG.constant_level_word);
            end
            TSGM_PATH_DATA: begin
               // The analog filter averages these bits into the ones-density level.
               n.sample    = SAMPLE_RST;
               n.bit_out   = s.sw_s2;
               n.bit_valid = 1'b1;
            end
            TSGM_PATH_PULSE: begin
               n.sample = SAMPLE_RST;
            end
         endcase
      end

      // Pulse path tracks sync every clock for precise timing, independent of the range.
      if (s.path == TSGM_PATH_PULSE) begin
         n.pulse_code = s.sync_s2 ? CFG.second_pulse_level : CFG.first_pulse_level;
      end else begin
         n.pulse_code = '0;
      end
      n.pulse_level = pulse_decode(s.pulse_code);

      // Outside data mode the pin gates the output switch.
      n.switch_en = (s.path != TSGM_PATH_DATA) && s.sw_s2;

      // Analog range and the summed attenuation in 0.5 dB units.
      n.range_out = CFG.range_code;
      if (CFG.sine_attenuation_code[7:4] == MUTE_NIBBLE || CFG.range_code > RANGE_MAX) begin
         n.total_atten = TOTAL_MUTE;
      end else begin
         n.total_atten = TOTAL_W'(CFG.range_code) * TOTAL_W'(STEPS_PER_6DB)
                       + TOTAL_W'(CFG.sine_attenuation_code);
      end
   end

   // State register with asynchronous reset to constants.
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s             <= '0;
         s.path        <= TSGM_PATH_SINE;
         s.sample      <= SAMPLE_RST;
         s.pulse_level <= PLEVEL_RST;
      end else begin
         s <= n;
      end
   end

   // Outputs come straight from the state register.
   assign ACTIVE_PATH    = s.path;
   assign SAMPLE_TICK    = s.tick;
   assign MOD_SAMPLE     = s.sample;
   assign DATA_BIT       = s.bit_out;
   assign DATA_BIT_VALID = s.bit_valid;
   assign SWITCH_ENABLE  = s.switch_en;
   assign PULSE_CODE     = s.pulse_code;
   assign PULSE_LEVEL    = s.pulse_level;
   assign RANGE_OUT      = s.range_out;
   assign TOTAL_ATTEN    = s.total_atten;

   // Checks on the generator behaviour.
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   // A steady mode field selects its path one clock later.
   property p_mode_path;
      $stable(CFG.mode) |=> (s.path == tsgm_path_t'(4'h1 << $past(CFG.mode)));
   endproperty
   a_mode_path: assert property (p_mode_path) else $error("Path does not follow mode.");

   // With num equal to den and no halving, each tick advances the phase by one.
   property p_phase_step;
      (s.tick && s.path == TSGM_PATH_SINE && !s.sync_s2 && !RATIO_WR
       && CFG.numerator == CFG.denominator[3:0] && CFG.denominator[7:4] == 4'h0
       && !CFG.rate_halving_bit && s.rem == '0)
      |=> (s.phase == $past(s.phase) + PHASE_W'(1));
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("Phase step wrong.");

   // Ticks come exactly DIV clocks apart: one quiet clock, then DIV-1 more to the next tick.
   property p_tick_period;
      s.tick |=> (!s.tick [*1] ##(DIV-1) s.tick);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("Tick spacing wrong.");

   // A ratio write restarts the wave at the zero crossing.
   property p_ratio_restart;
      RATIO_WR |=> (s.phase == '0 && s.rem == '0);
   endproperty
   a_ratio_restart: assert property (p_ratio_restart) else $error("No restart.");

   // A sync pulse in sine mode zeroes the phase within three clocks.
   sequence s_sync_rise;
      $rose(SYNC_IN) && s.path == TSGM_PATH_SINE && CFG.mode == MODE_SINE;
   endsequence
   sequence s_sync_held;
      SYNC_IN [*3];
   endsequence
   property p_sync_zero;
      s_sync_rise ##0 s_sync_held |=> (s.phase == '0);
   endproperty
   a_sync_zero: assert property (p_sync_zero) else $error("Sync did not zero.");

   // Pulse code follows the synchronised sync level.
   property p_pulse_pick;
      (s.path == TSGM_PATH_PULSE)
      |=> (s.pulse_code == ($past(s.sync_s2) ? $past(CFG.second_pulse_level)
                                             : $past(CFG.first_pulse_level)));
   endproperty
   a_pulse_pick: assert property (p_pulse_pick) else $error("Pulse level pick wrong.");

   // The positive full-scale code 01111 decodes to the positive extreme.
   property p_pulse_full;
      (s.pulse_code == 5'h0f) |=> (s.pulse_level == 16'sh7fff);
   endproperty
   a_pulse_full: assert property (p_pulse_full) else $error("Pulse full scale wrong.");

   // A mute code gives a zero sample at the next tick.
   property p_mute;
      (s.tick && s.path == TSGM_PATH_SINE && CFG.sine_attenuation_code[7:4] == MUTE_NIBBLE)
      |=> (s.sample == SAMPLE_RST);
   endproperty
   a_mute: assert property (p_mute) else $error("Mute failed.");

   // Dc mode passes the level word at each tick.
   property p_dc_level;
      (s.tick && s.path == TSGM_PATH_DC) |=> (s.sample == $signed($past(CFG.constant_level_word)));
   endproperty
   a_dc_level: assert property (p_dc_level) else $error("Dc level wrong.");

   // Total attenuation is range octaves plus digital steps.
   property p_total;
      (CFG.range_code <= RANGE_MAX && CFG.sine_attenuation_code[7:4] != MUTE_NIBBLE)
      |=> (s.total_atten == TOTAL_W'($past(CFG.range_code)) * TOTAL_W'(STEPS_PER_6DB)
                            + TOTAL_W'($past(CFG.sine_attenuation_code)));
   endproperty
   a_total: assert property (p_total) else $error("Total attenuation wrong.");

endmodule

// ---- sim/tsgm_sync_src.sv ----
`timescale 1ns/1ps
// Acquisition timing source that drives the sync pin and the switch or bitstream pin.
module tsgm_sync_src #(
   parameter int DIV  = 4,   // Master clocks per bitstream bit.
   parameter int SLOW = 5    // Extra clocks that a slow answer holds back.
)(
   input  wire logic ref_clk,
   input  wire logic sync_req,
   input  wire logic slow,
   input  wire logic stream_on,
   input  wire logic pin_level,
   output      logic sync_out,
   output      logic switch_or_bitstream_input
);
   logic       req_r    = 1'b0;   // Sync request seen at the last rising edge.
   int         wait_cnt = 0;      // Clocks the slow answer has waited so far.
   int         div_cnt  = 0;      // Clocks into the current bitstream bit.
   logic [1:0] bit_idx  = 2'h0;   // Place in the repeating one-one-one-zero pattern.

   // The request is taken on the rising edge so the pin moves half a period later.
   always @(posedge ref_clk) begin
      req_r <= sync_req;
   end

   // Both pins change just after the falling edge, never near the sampling edge.
   initial begin
      sync_out = 1'b0;
      switch_or_bitstream_input    = 1'b1;
      forever begin
         @(negedge ref_clk);
         // A slow source holds the new sync level back for a few clocks.
         if (req_r !== sync_out) begin
            if (slow && wait_cnt < SLOW) begin
               wait_cnt++;
            end else begin
               sync_out = req_r;
               wait_cnt = 0;
            end
         end
         // Bitstream at one bit per DIV clocks, three ones in four for a 75 percent density.
         if (stream_on) begin
            div_cnt = (div_cnt + 1) % DIV;
            if (div_cnt == 0) begin
               bit_idx++;
            end
            switch_or_bitstream_input = (bit_idx != 2'h3);
         end else begin
            switch_or_bitstream_input = pin_level;
         end
      end
   end
endmodule

// ---- sim/tb_test_signal_generator_modes.sv ----
`timescale 1ns/1ps
// Self-checking bench: the pins come from the timing source, the configuration from here.
module tb_test_signal_generator_modes;
   import tsgm_pkg::*;
   localparam int DIVS = 4;              // Short sample divider keeps the sine runs brief.
   logic              ref_clk;          // Master clock.
   logic              resetn;           // Active-low reset.
   tsgm_cfg_t         cfg;              // Configuration word.
   logic              ratio_wr;         // Numerator or denominator write strobe.
   logic              sync_req;         // Sync level asked of the timing source.
   logic              slow;             // Timing source answers late when high.
   logic              stream_on;        // Timing source sends the bitstream when high.
   logic              pin_level;        // Switch pin level outside bitstream use.
   logic              sync_w;           // Sync pin.
   logic              pin_w;            // Switch or bitstream pin.
   tsgm_path_t        path;             // Active data path.
   logic              tick;             // Sample tick.
   logic signed [23:0] sample;          // Modulator sample.
   logic              dbit;             // Sampled bitstream bit.
   logic              dvalid;           // Bitstream bit strobe.
   logic              sw_en;            // Switch enable.
   logic [4:0]        pcode;            // Selected pulse code.
   logic signed [15:0] plevel;          // Decoded pulse level.
   logic [2:0]        range_o;          // Range code out.
   logic [8:0]        total;            // Total attenuation in half-decibel units.
   int                bad_count;        // Mismatches seen.
   int                samples_checked;  // Comparisons made.
   int                ones;             // Ones counted in the bitstream.
   int                gap;              // Clocks between two ticks.
   // Range, digital code and expected total attenuation, mute cases included.
   logic [19:0]       att_tab [7] = '{{3'h0, 8'h00, 9'h000}, {3'h1, 8'h01, 9'h00d},
      {3'h3, 8'h05, 9'h029}, {3'h6, 8'hef, 9'h137}, {3'h0, 8'hf0, 9'h1ff},
      {3'h2, 8'hff, 9'h1ff}, {3'h7, 8'h00, 9'h1ff}};
   // Dc level words from zero to both ends of the scale.
   logic [23:0]       dc_tab [4] = '{24'h000000, 24'hc00000, 24'h800001, 24'h7fffff};

   tsgm_top #(.DIV(DIVS)) dut (.REF_CLK(ref_clk), .RESETN(resetn), .CFG(cfg),
      .RATIO_WR(ratio_wr), .SYNC_IN(sync_w), .SWITCH_OR_BITSTREAM_INPUT(pin_w),
      .ACTIVE_PATH(path), .SAMPLE_TICK(tick), .MOD_SAMPLE(sample), .DATA_BIT(dbit),
      .DATA_BIT_VALID(dvalid), .SWITCH_ENABLE(sw_en), .PULSE_CODE(pcode),
      .PULSE_LEVEL(plevel), .RANGE_OUT(range_o), .TOTAL_ATTEN(total));

   tsgm_sync_src #(.DIV(DIVS)) partner (.ref_clk(ref_clk), .sync_req(sync_req), .slow(slow),
      .stream_on(stream_on), .pin_level(pin_level), .sync_out(sync_w), .switch_or_bitstream_input(pin_w));

   // Prints the verdict and stops the run.
   task end_sim;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one and reports a difference.
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Moves on by whole clocks, landing on a falling edge.
   task step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Waits for the next sample tick under a bound and returns the clocks it took.
   task wait_tick(output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (tick !== 1'b1 && n < 64);
      if (tick !== 1'b1) begin
         bad_count++;
         $display("MISMATCH %0t sample tick missing", $time);
         end_sim();
      end
   endtask

   // Lets a number of sample ticks pass.
   task ticks(input int n);
      int d;
      repeat (n) wait_tick(d);
   endtask

   // One-clock write strobe for the frequency ratio.
   task strobe;
      ratio_wr = 1'b1;
      step(1);
      ratio_wr = 1'b0;
   endtask

   // Free-running master clock.
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Main sequence.
   initial begin
      resetn = 1'b0;
      cfg = '0;
      ratio_wr = 1'b0;
      sync_req = 1'b0;
      slow = 1'b0;
      stream_on = 1'b0;
      pin_level = 1'b1;
      bad_count = 0;
      samples_checked = 0;
      step(3);
      chk(24'(path), 24'(TSGM_PATH_SINE));
      resetn = 1'b1;
      // Every mode code selects its own path.
      for (int m = 0; m < 4; m++) begin
         cfg.mode = 2'(m);
         step(2);
         chk(24'(path), 24'(4'h1 << m));
      end
      // Range plus digital attenuation, with mute and the unused range code.
      for (int k = 0; k < 7; k++) begin
         {cfg.range_code, cfg.sine_attenuation_code} = att_tab[k][19:9];
         step(2);
         chk(24'(range_o), 24'(att_tab[k][19:17]));
         chk(24'(total), 24'(att_tab[k][8:0]));
      end
      // Pulse levels chosen by the sync pin, blind to the range code.
      cfg.range_code = 3'h0;
      cfg.sine_attenuation_code = 8'h00;
      cfg.mode = MODE_PULSE;
      cfg.first_pulse_level = 5'h0f;
      cfg.second_pulse_level = 5'h11;
      step(3);
      chk(24'(pcode), 24'h00000f);
      chk(24'(plevel[15:0]), 24'h007fff);
      cfg.range_code = 3'h6;
      step(3);
      chk(24'(plevel[15:0]), 24'h007fff);
      sync_req = 1'b1;
      step(3);
      chk(24'(pcode), 24'h00000f);
      step(1);
      chk(24'(pcode), 24'h000011);
      step(1);
      chk(24'(plevel[15:0]), 24'h008001);
      chk(sample, 24'h000000);
      cfg.second_pulse_level = 5'h1f;
      step(3);
      chk(24'(plevel[15]), 24'h000001);
      sync_req = 1'b0;
      cfg.first_pulse_level = 5'h00;
      step(6);
      chk(24'(pcode), 24'h000000);
      chk(24'(plevel[15:0]), 24'h000000);
      slow = 1'b1;
      sync_req = 1'b1;
      step(12);
      chk(24'(pcode), 24'h00001f);
      sync_req = 1'b0;
      slow = 1'b0;
      // Dc words are passed as two's complement over the chosen range.
      cfg.mode = MODE_DC;
      cfg.range_code = 3'h0;
      for (int k = 0; k < 4; k++) begin
         cfg.constant_level_word = dc_tab[k];
         ticks(2);
         step(1);
         chk(sample, dc_tab[k]);
      end
      wait_tick(gap);
      wait_tick(gap);
      chk(24'(gap), 24'(DIVS));
      // The pin gates the switch outside data mode only.
      cfg.mode = MODE_SINE;
      step(6);
      chk(24'(sw_en), 24'h000001);
      pin_level = 1'b0;
      step(6);
      chk(24'(sw_en), 24'h000000);
      pin_level = 1'b1;
      cfg.mode = MODE_DATA;
      step(6);
      chk(24'(sw_en), 24'h000000);
      // A 75 percent stream is passed one bit per tick.
      stream_on = 1'b1;
      step(20);
      ones = 0;
      for (int b = 0; b < 64; b++) begin
         ticks(1);
         step(1);
         if (b == 0) chk(24'(dvalid), 24'h000001);
         ones += int'(dbit === 1'b1);
      end
      chk(24'(ones), 24'h000030);
      stream_on = 1'b0;
      // Sine held at the zero crossing by sync, then left to run.
      cfg.mode = MODE_SINE;
      cfg.numerator = 4'h0;
      cfg.denominator = 8'h00;
      sync_req = 1'b1;
      strobe();
      ticks(8);
      step(1);
      chk(sample, 24'h000000);
      sync_req = 1'b0;
      ticks(256);
      step(1);
      chk(24'(sample[23]), 24'h000000);
      chk(24'(sample != 24'sh0), 24'h000001);
      ticks(512);
      step(1);
      chk(24'(sample[23]), 24'h000001);
      // A ratio write brings the wave back to its zero crossing.
      cfg.denominator = 8'hff;
      strobe();
      ticks(3);
      step(1);
      chk(sample, 24'h000000);
      // The halving bit doubles the period.
      cfg.denominator = 8'h00;
      cfg.rate_halving_bit = 1'b1;
      strobe();
      ticks(768);
      step(1);
      chk(24'(sample[23]), 24'h000000);
      chk(24'(sample != 24'sh0), 24'h000001);
      cfg.sine_attenuation_code = 8'hf0;
      ticks(2);
      step(1);
      chk(sample, 24'h000000);
      end_sim();
   end
endmodule
